/* verif/psm_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Bus master model: drives SCL, pulls SDA low with sda_oe, line has a pull-up
module psm_host_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_oe
);
    // Quarter bit time in clocks; scaled down from the bus rate to keep runs short
    int q = 10;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic hq();
        repeat (q) @(posedge sys_clk);
        #1;
    endtask
    // Also serves as repeated start: data is released before the clock rises
    task automatic start();
        sda_oe = 1'b0;
        hq();
        scl = 1'b1;
        hq();
        sda_oe = 1'b1;
        hq();
        scl = 1'b0;
        hq();
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        hq();
        scl = 1'b1;
        hq();
        sda_oe = 1'b0;
        hq();
        // Bus free gap shortened: stores in this block complete at once
        hq();
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_oe = !b;
        hq();
        scl = 1'b1;
        hq();
        r = sda_line;
        hq();
        scl = 1'b0;
        hq();
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(v[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            v[i] = r;
        end
        bit_x(nack, r);
    endtask
endmodule
`default_nettype wire

/* verif/psu_smbus_slave_with_eeprom_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module psu_smbus_slave_with_eeprom_tb import psm_pkg::*;;
    logic sys_clk = 1'b0, nrst = 1'b0, wp_in = 1'b0, shutdown_event = 1'b0, warning_event = 1'b0;
    logic scl_in, host_oe, sda_out, sda_oe, fault_alert_n, cmd_wr_stb, cmd_done, ack, r, ov;
    wire logic sda_line;
    logic [7:0] cmd_code, cmd_wr_data, cmd_wr_idx, cmd_len, cmd_rd_idx, cmd_rd_data, loc, d, code;
    logic [7:0] shadow [256] = '{default: 8'h00};
    logic [7:0] stb_q [$];
    logic [7:0] xd [$];
    int error_cnt = 0, n_checks = 0, done_n = 0;
    integer seed = 32'he389c337;
    int lens [5] = '{0, 1, 2, 254, 255};
    logic [7:0] bad [3] = '{8'h22, 8'ha2, 8'h40};
    always #5 sys_clk = ~sys_clk;
    assign sda_line = ~(host_oe | (sda_oe & ~sda_out));
    assign cmd_rd_data = cmd_code ^ cmd_rd_idx ^ 8'h5a;
    psm_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl_in), .sda_oe(host_oe));
    psm_smbus_slave #(.SCL_LOW_CYC(200)) DUT (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in),
        .shutdown_event(shutdown_event), .warning_event(warning_event), .fault_alert_n(fault_alert_n),
        .cmd_code(cmd_code), .cmd_wr_stb(cmd_wr_stb), .cmd_wr_data(cmd_wr_data), .cmd_wr_idx(cmd_wr_idx),
        .cmd_done(cmd_done), .cmd_len(cmd_len), .cmd_rd_idx(cmd_rd_idx), .cmd_rd_data(cmd_rd_data));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] rd_exp(input logic [7:0] c, input int i);
        return c ^ 8'(i) ^ 8'h5a;
    endfunction
    task automatic ee_wr(input logic [7:0] a, input logic [7:0] v);
        host.start();
        host.wbyte(PSM_ADDR_EE, ack);
        chk({7'h0, ack}, 8'h01);
        host.wbyte(a, ack);
        host.wbyte(v, ack);
        chk({7'h0, ack}, 8'h01);
        host.stop();
    endtask
    task automatic ee_rd(input logic [7:0] a, output logic [7:0] v);
        host.start();
        host.wbyte(PSM_ADDR_EE, ack);
        host.wbyte(a, ack);
        host.start();
        host.wbyte(PSM_ADDR_EE | 8'h01, ack);
        chk({7'h0, ack}, 8'h01);
        host.rbyte(1'b1, v);
        host.stop();
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (cmd_wr_stb === 1'b1) begin
            chk(cmd_wr_idx, 8'(stb_q.size()));
            stb_q.push_back(cmd_wr_data);
        end
        if (cmd_done === 1'b1) begin
            done_n++;
        end
    end
    // Guard against a hung handshake
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        results();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        chk({6'h0, sda_oe, fault_alert_n}, 8'h01);
        repeat (4) @(posedge sys_clk);
        #1;
        for (int i = 0; i < 16; i++) begin
            {shutdown_event, warning_event} = 2'($random(seed));
            repeat (2) @(posedge sys_clk);
            #1;
            chk({7'h0, fault_alert_n}, {7'h0, ~(shutdown_event | warning_event)});
        end
        // Single-byte store traffic, fast and slow host
        for (int i = 0; i < 3; i++) begin
            host.q = i[0] ? 25 : 10;
            loc = 8'($random(seed));
            d = 8'($random(seed));
            ee_wr(loc, d);
            shadow[loc] = d;
            ee_rd(loc, code);
            chk(code, d);
        end
        wp_in = 1'b1;
        ee_wr(loc, ~d);
        ee_rd(loc, code);
        chk(code, shadow[loc]);
        wp_in = 1'b0;
        foreach (bad[i]) begin
            host.start();
            host.wbyte(bad[i], ack);
            chk({7'h0, ack}, 8'h00);
            host.stop();
        end
        // Command writes: code alone, byte, word, longest block, one byte past it
        // Long blocks run at a short bit time to stay inside the cycle budget
        foreach (lens[k]) begin
            host.q = (lens[k] > 2) ? 3 : 10;
            ov = (lens[k] > 254);
            stb_q.delete();
            xd.delete();
            done_n = 0;
            code = 8'($random(seed));
            host.start();
            host.wbyte(PSM_ADDR_CMD, ack);
            chk({7'h0, ack}, 8'h01);
            host.wbyte(code, ack);
            for (int j = 0; j < lens[k]; j++) begin
                xd.push_back(8'($random(seed)));
                host.wbyte(xd[j], ack);
            end
            chk({7'h0, ack}, {7'h0, !ov});
            host.stop();
            chk(8'(done_n), {7'h0, !ov});
            chk(cmd_len, ov ? 8'hff : 8'(lens[k] + 1));
            chk(cmd_code, code);
            chk(8'(stb_q.size()), ov ? 8'hfe : 8'(lens[k]));
            foreach (stb_q[j]) chk(stb_q[j], xd[j]);
        end
        host.q = 10;
        code = 8'($random(seed));
        host.start();
        host.wbyte(PSM_ADDR_CMD, ack);
        host.wbyte(code, ack);
        host.start();
        host.wbyte(PSM_ADDR_CMD | 8'h01, ack);
        for (int j = 0; j < 3; j++) begin
            host.rbyte(j == 2, d);
            chk(d, rd_exp(code, j));
        end
        host.stop();
        // Clock held low during the acknowledge slot
        host.start();
        host.wbyte(PSM_ADDR_EE, ack);
        for (int i = 7; i >= 0; i--) host.bit_x(loc[i], r);
        repeat (300) @(posedge sys_clk);
        #1;
        chk({7'h0, sda_oe}, 8'h00);
        host.wbyte(~d, ack);
        chk({7'h0, ack}, 8'h00);
        host.stop();
        host.start();
        for (int i = 7; i >= 4; i--) host.bit_x(PSM_ADDR_EE[i], r);
        d = 8'($random(seed));
        ee_wr(loc, d);
        ee_rd(loc, code);
        chk(code, d);
        results();
    end
endmodule
`default_nettype wire

/* verilog/psm_pkg.sv */
`default_nettype none
package psm_pkg;

    // Fixed target addresses, direction bit in bit 0
    localparam logic [7:0] PSM_ADDR_CMD = 8'h20;
    localparam logic [7:0] PSM_ADDR_EE = 8'ha0;

    // Clock period and SCL low timeout, both in ns (10 ns, 25 ms)
    localparam int unsigned PSM_CLK_PERIOD_NS = 32'h0000_000a;
    localparam int unsigned PSM_SCL_LOW_TMO_NS = 32'h017d_7840;
    localparam int unsigned PSM_TMO_W = 32'h0000_0016;

    // Bits per byte, block length ceiling, filler past the block end
    localparam logic [3:0] PSM_BITS = 4'h8;
    localparam logic [8:0] PSM_BLK_MAX = 9'h0ff;
    localparam logic [7:0] PSM_RD_MAX = 8'hff;
    localparam logic [7:0] PSM_FILL = 8'hff;
    localparam int unsigned PSM_EE_BYTES = 32'h0000_0100;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_MACK = 3'b101,
        ST_IGNORE = 3'b110
    } psm_state_type;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic wp_s1;
        logic wp_s2;
        psm_state_type st;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic tgt_ee;
        logic rd;
        logic ack_ok;
        logic [8:0] nbytes;
        logic [7:0] ptr;
        logic [7:0] code;
        logic [7:0] rd_idx;
        logic [PSM_TMO_W-1:0] low_cnt;
        logic sda_o;
        logic sda_oe;
        logic alert_n;
        logic wr_stb;
        logic [7:0] wr_data;
        logic [7:0] wr_idx;
        logic done_stb;
        logic [7:0] len;
        logic [PSM_EE_BYTES-1:0][7:0] mem;
    } psm_regs_type;

endpackage
`default_nettype wire

/* verilog/psm_smbus_slave.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1 - Command target answers only at 0x20
// R2 - EEPROM target answers only at 0xA0
// R3 - Both targets decode the same shared bus
// R4 - Write lock high refuses EEPROM writes
// R5 - EEPROM holds 2K bits, unused internally
// R6 - Host should prefer single-byte EEPROM transfers
// R7 - EEPROM write: address, location, data, stop
// R8 - Host waits 5 ms after EEPROM write
// R9 - EEPROM read: location, repeated start, read
// R10 - Command code is an operation, not index
// R11 - Clock never stretched beyond 1 ms
// R12 - SCL low past 25 ms abandons transfer
// R13 - Start and stop recognised at any time
// R14 - Command write ends after 0-2 data bytes
// R15 - Block writes limited to 255 bytes
// R16 - Byte and word reads via repeated start
// R17 - Block reads limited to 255 bytes
// R18 - Device is target only, never initiates
// R19 - Host clocks bus at 100 kbps maximum
// R20 - Alert low on any shutdown or warning
// R21 - Locked write still acknowledged, data unchanged
module psm_smbus_slave import psm_pkg::*; #(
    parameter int unsigned SCL_LOW_CYC = (PSM_SCL_LOW_TMO_NS + PSM_CLK_PERIOD_NS - 1) / PSM_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic wp_in,
    input wire logic shutdown_event,
    input wire logic warning_event,
    output logic fault_alert_n,
    output logic [7:0] cmd_code,
    output logic cmd_wr_stb,
    output logic [7:0] cmd_wr_data,
    output logic [7:0] cmd_wr_idx,
    output logic cmd_done,
    output logic [7:0] cmd_len,
    output logic [7:0] cmd_rd_idx,
    input wire logic [7:0] cmd_rd_data
);

    psm_regs_type r;
    psm_regs_type n;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic tmo;
    logic do_load;
    logic [7:0] tx_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Bus events, seen only on the second and third sampling stages
    assign scl_rise = r.scl_s2 & ~r.scl_d;
    assign scl_fall = ~r.scl_s2 & r.scl_d;
    assign bus_start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    assign bus_stop = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    assign tmo = {{(32 - PSM_TMO_W){1'b0}}, r.low_cnt} >= SCL_LOW_CYC - 1;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        do_load = 1'b0;
        tx_byte = PSM_FILL;
        n.scl_s1 = scl_in;
        n.scl_s2 = r.scl_s1;
        n.scl_d = r.scl_s2;
        n.sda_s1 = sda_in;
        n.sda_s2 = r.sda_s1;
        n.sda_d = r.sda_s2;
        n.wp_s1 = wp_in;
        n.wp_s2 = r.wp_s1;
        n.wr_stb = 1'b0;
        n.done_stb = 1'b0;
        n.alert_n = ~(shutdown_event | warning_event); // R20
        // SCL is input only: no stretching, no bus mastering
        n.sda_o = 1'b0; // R11 R18
        if (r.st != ST_IDLE && !r.scl_s2) begin
            n.low_cnt = r.low_cnt + 1'b1;
        end else begin
            n.low_cnt = '0;
        end
        if (bus_start) begin // R13
            n.st = ST_ADDR;
            n.bcnt = '0;
            n.nbytes = '0;
            n.sda_oe = 1'b0;
        end else if (bus_stop) begin // R13
            // Command writes only report on a clean stop; overruns are dropped
            if (!r.tgt_ee && !r.rd && (r.st == ST_ACK || r.st == ST_RX)) begin // R14
                n.done_stb = 1'b1;
                n.len = r.nbytes[7:0];
            end
            n.st = ST_IDLE;
            n.sda_oe = 1'b0;
        end else if (tmo) begin // R12
            n.st = ST_IDLE;
            n.sda_oe = 1'b0;
            n.low_cnt = '0;
        end else begin
            case (r.st)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], r.sda_s2};
                        n.bcnt = r.bcnt + 1'b1;
                    end else if (scl_fall && r.bcnt == PSM_BITS) begin
                        n.bcnt = '0;
                        if (r.st == ST_ADDR) begin
                            n.rd = r.sh[0];
                            n.st = ST_ACK;
                            n.sda_oe = 1'b1;
                            n.rd_idx = '0;
                            if (r.sh[7:1] == PSM_ADDR_CMD[7:1]) begin // R1 R3
                                n.tgt_ee = 1'b0;
                            end else if (r.sh[7:1] == PSM_ADDR_EE[7:1]) begin // R2 R3
                                n.tgt_ee = 1'b1;
                            end else begin // R18
                                n.st = ST_IGNORE;
                                n.sda_oe = 1'b0;
                            end
                        end else if (r.nbytes == PSM_BLK_MAX) begin // R15
                            n.st = ST_IGNORE;
                        end else begin
                            n.nbytes = r.nbytes + 1'b1;
                            n.st = ST_ACK;
                            n.sda_oe = 1'b1;
                            if (r.tgt_ee) begin
                                if (r.nbytes == '0) begin // R7 R9
                                    n.ptr = r.sh;
                                end else begin
                                    // Locked writes are still acknowledged
                                    if (!r.wp_s2) begin // R4 R21
                                        n.mem[r.ptr] = r.sh; // R5 R7
                                    end
                                    n.ptr = r.ptr + 1'b1;
                                end
                            end else if (r.nbytes == '0) begin
                                n.code = r.sh; // R10
                            end else begin
                                n.wr_stb = 1'b1; // R14 R15
                                n.wr_data = r.sh;
                                n.wr_idx = r.nbytes[7:0] - 8'h01;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        if (r.rd) begin
                            do_load = 1'b1;
                        end else begin
                            n.st = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (r.bcnt == PSM_BITS) begin
                            n.sda_oe = 1'b0;
                            n.st = ST_MACK;
                        end else begin
                            n.sda_oe = ~r.sh[6];
                            n.sh = {r.sh[6:0], 1'b0};
                            n.bcnt = r.bcnt + 1'b1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        n.ack_ok = ~r.sda_s2;
                    end else if (scl_fall) begin
                        if (r.ack_ok) begin
                            do_load = 1'b1;
                        end else begin
                            n.st = ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                end
                default: begin
                    n.st = ST_IDLE;
                end
            endcase
        end
        // Byte load for a read; cmd_rd_data is sampled in this very cycle
        if (do_load) begin
            if (r.tgt_ee) begin // R9
                tx_byte = r.mem[r.ptr];
                n.ptr = r.ptr + 1'b1;
            end else begin // R16 R17
                tx_byte = (r.rd_idx == PSM_RD_MAX) ? PSM_FILL : cmd_rd_data;
                if (r.rd_idx != PSM_RD_MAX) begin
                    n.rd_idx = r.rd_idx + 1'b1;
                end
            end
            n.sh = tx_byte;
            n.sda_oe = ~tx_byte[7];
            n.bcnt = 4'h1;
            n.st = ST_TX;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            r <= psm_regs_type'(0);
            r.alert_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign sda_out = r.sda_o;
    assign sda_oe = r.sda_oe;
    assign fault_alert_n = r.alert_n;
    assign cmd_code = r.code;
    assign cmd_wr_stb = r.wr_stb;
    assign cmd_wr_data = r.wr_data;
    assign cmd_wr_idx = r.wr_idx;
    assign cmd_done = r.done_stb;
    assign cmd_len = r.len;
    assign cmd_rd_idx = r.rd_idx;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence byte_end_s;
        !bus_start && !bus_stop && !tmo && scl_fall && r.bcnt == PSM_BITS;
    endsequence
    sequence addr_end_s;
        r.st == ST_ADDR ##0 byte_end_s;
    endsequence
    sequence ee_data_s;
        r.st == ST_RX && r.tgt_ee && r.nbytes != '0 && r.nbytes != PSM_BLK_MAX ##0 byte_end_s;
    endsequence

    cmd_addr_ack_a: assert property (addr_end_s ##0 r.sh[7:1] == PSM_ADDR_CMD[7:1] // R1
        |=> r.sda_oe && !r.tgt_ee && r.st == ST_ACK) else $error("command address not acknowledged");
    ee_addr_ack_a: assert property (addr_end_s ##0 r.sh[7:1] == PSM_ADDR_EE[7:1] // R2
        |=> r.sda_oe && r.tgt_ee) else $error("EEPROM address not acknowledged");
    foreign_addr_a: assert property (addr_end_s ##0 r.sh[7:1] != PSM_ADDR_CMD[7:1] // R18
        && r.sh[7:1] != PSM_ADDR_EE[7:1] |=> !r.sda_oe [*2]) else $error("foreign address acknowledged");
    ee_lock_a: assert property (ee_data_s ##0 r.wp_s2 |=> r.sda_oe && $stable(r.mem)) // R4
        else $error("locked EEPROM changed or refused");
    ee_write_a: assert property (ee_data_s ##0 !r.wp_s2 |=> r.mem[$past(r.ptr)] == $past(r.sh)) // R7
        else $error("EEPROM byte not stored");
    start_stop_a: assert property (bus_start |=> r.st == ST_ADDR ##1 r.st != ST_IDLE || bus_stop) // R13
        else $error("start not taken");
    stop_idle_a: assert property (bus_stop |=> r.st == ST_IDLE && !r.sda_oe) else $error("stop not taken"); // R13
    scl_tmo_a: assert property (tmo && !bus_start && !bus_stop |=> r.st == ST_IDLE && r.low_cnt == '0) // R12
        else $error("SCL low timeout not taken");
    alert_or_a: assert property (fault_alert_n == !$past(shutdown_event || warning_event)) // R20
        else $error("alert does not follow the events");
    // A byte past the block limit is refused: no ACK and no strobe
    blk_len_a: assert property (r.st == ST_RX ##0 byte_end_s ##0 r.nbytes == PSM_BLK_MAX // R15
        |=> r.st == ST_IGNORE && !r.sda_oe && !r.wr_stb) else $error("block length exceeded");

endmodule
`default_nettype wire
